// ===== rtl/adc_result_format_config.sv
// Local design decisions: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
// Overview of operation
// - Left justify puts result 9:2 in high
// - Left justify puts result 1:0 in low 7:6
// - Right justify puts result 9:8 in high 1:0
// - Reference select: supply, external pin, fixed reference
// - Config bits 3-2 read zero, ignore writes
// - Result bytes unknown at power-up, kept otherwise
// - Result bytes fully software readable and writable
module adc_result_format_config (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  output logic [7:0] rd_data_out,
  input wire logic [9:0] conversion_result_in,
  input wire logic result_load_in,
  input wire logic dedicated_rc_clock_in,
  output logic [1:0] pos_ref_select_out,
  output logic result_justify_select_out,
  output logic [2:0] conv_clock_select_out,
  output logic conv_clock_tick_out
);

  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic [7:0] rd_data_r;
  logic [7:0] rd_data_nxt;
  logic [5:0] div_cnt_r;
  logic [5:0] div_cnt_nxt;
  logic [5:0] div_tc;
  logic tick_r;
  logic tick_nxt;
  logic rc_meta_r;
  logic rc_sync_r;
  logic rc_prev_r;
  logic use_rc;
  logic [7:0] high_q;
  logic [7:0] low_q;
  logic high_we;
  logic low_we;
  logic [7:0] high_wd;
  logic [7:0] low_wd;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register

  // Unimplemented bits are masked off so they never store a one
  always_comb
  begin
    cfg_nxt = cfg_r;
    if (wr_en_in && addr_in == adc_fmt_pkg::ADDR_CFG)
    begin
      cfg_nxt = wr_data_in & adc_fmt_pkg::CFG_WRITE_MASK;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg_r <= adc_fmt_pkg::CFG_RESET;
    end
    else
    begin
      cfg_r <= cfg_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result formatting and storage

  // Software write to a byte wins over a converter load in the same cycle
  always_comb
  begin
    high_we = result_load_in;
    low_we = result_load_in;
    if (cfg_r[adc_fmt_pkg::JUSTIFY_BIT] == adc_fmt_pkg::JUSTIFY_LEFT)
    begin
      high_wd = conversion_result_in[adc_fmt_pkg::RES_MSB:adc_fmt_pkg::LEFT_HIGH_LSB];
      low_wd = {conversion_result_in[adc_fmt_pkg::LEFT_LOW_MSB:adc_fmt_pkg::RES_LSB],
        adc_fmt_pkg::PAD6};
    end
    else
    begin
      high_wd = {adc_fmt_pkg::PAD6,
        conversion_result_in[adc_fmt_pkg::RES_MSB:adc_fmt_pkg::RIGHT_HIGH_LSB]};
      low_wd = conversion_result_in[adc_fmt_pkg::RIGHT_LOW_MSB:adc_fmt_pkg::RES_LSB];
    end
    if (wr_en_in && addr_in == adc_fmt_pkg::ADDR_RES_HIGH)
    begin
      high_we = 1'b1;
      high_wd = wr_data_in;
    end
    if (wr_en_in && addr_in == adc_fmt_pkg::ADDR_RES_LOW)
    begin
      low_we = 1'b1;
      low_wd = wr_data_in;
    end
  end

  adc_result_store u_store (
    .clk_in(clk_in),
    .high_we_in(high_we),
    .high_wd_in(high_wd),
    .low_we_in(low_we),
    .low_wd_in(low_wd),
    .high_q_out(high_q),
    .low_q_out(low_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read port: data valid only in the cycle after the strobe

  always_comb
  begin
    rd_data_nxt = adc_fmt_pkg::BYTE_ZERO;
    if (rd_en_in)
    begin
      case (addr_in)
        adc_fmt_pkg::ADDR_CFG: rd_data_nxt = cfg_r;
        adc_fmt_pkg::ADDR_RES_HIGH: rd_data_nxt = high_q;
        adc_fmt_pkg::ADDR_RES_LOW: rd_data_nxt = low_q;
        default: rd_data_nxt = adc_fmt_pkg::BYTE_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_data_r <= adc_fmt_pkg::BYTE_ZERO;
    end
    else
    begin
      rd_data_r <= rd_data_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock: divider enable or synchronised RC clock edge

  // RC clock is asynchronous; first stage feeds only the second
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rc_meta_r <= 1'b0;
      rc_sync_r <= 1'b0;
      rc_prev_r <= 1'b0;
    end
    else
    begin
      rc_meta_r <= dedicated_rc_clock_in;
      rc_sync_r <= rc_meta_r;
      rc_prev_r <= rc_sync_r;
    end
  end

  // Map select code to divider terminal count
  always_comb
  begin
    use_rc = 1'b0;
    case (cfg_r[adc_fmt_pkg::CLKSEL_HI:adc_fmt_pkg::CLKSEL_LO])
      adc_fmt_pkg::CLK_DIV2: div_tc = adc_fmt_pkg::TC_DIV2;
      adc_fmt_pkg::CLK_DIV4: div_tc = adc_fmt_pkg::TC_DIV4;
      adc_fmt_pkg::CLK_DIV8: div_tc = adc_fmt_pkg::TC_DIV8;
      adc_fmt_pkg::CLK_DIV16: div_tc = adc_fmt_pkg::TC_DIV16;
      adc_fmt_pkg::CLK_DIV32: div_tc = adc_fmt_pkg::TC_DIV32;
      adc_fmt_pkg::CLK_DIV64: div_tc = adc_fmt_pkg::TC_DIV64;
      default:
      begin
        div_tc = adc_fmt_pkg::TC_DIV2;
        use_rc = 1'b1;
      end
    endcase
  end

  // Counter restarts when it passes a lowered terminal count
  always_comb
  begin
    div_cnt_nxt = div_cnt_r + adc_fmt_pkg::CNT_STEP;
    tick_nxt = 1'b0;
    if (use_rc)
    begin
      div_cnt_nxt = adc_fmt_pkg::CNT_ZERO;
      tick_nxt = rc_sync_r & ~rc_prev_r;
    end
    else if (div_cnt_r >= div_tc)
    begin
      div_cnt_nxt = adc_fmt_pkg::CNT_ZERO;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_cnt_r <= adc_fmt_pkg::CNT_ZERO;
      tick_r <= 1'b0;
    end
    else
    begin
      div_cnt_r <= div_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs; reserved reference code 01 is passed through unchanged

  assign rd_data_out = rd_data_r;
  assign pos_ref_select_out = cfg_r[adc_fmt_pkg::REFSEL_HI:adc_fmt_pkg::REFSEL_LO];
  assign result_justify_select_out = cfg_r[adc_fmt_pkg::JUSTIFY_BIT];
  assign conv_clock_select_out = cfg_r[adc_fmt_pkg::CLKSEL_HI:adc_fmt_pkg::CLKSEL_LO];
  assign conv_clock_tick_out = tick_r;

endmodule

// ===== rtl/adc_fmt_pkg.sv
package adc_fmt_pkg;

  // Register word addresses on the plain register port
  localparam int ADDR_W = 2;
  localparam logic [1:0] ADDR_CFG = 2'h0;
  localparam logic [1:0] ADDR_RES_HIGH = 2'h1;
  localparam logic [1:0] ADDR_RES_LOW = 2'h2;

  // Configuration register layout
  localparam int JUSTIFY_BIT = 7;
  localparam int CLKSEL_HI = 6;
  localparam int CLKSEL_LO = 4;
  localparam int REFSEL_HI = 1;
  localparam int REFSEL_LO = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'hF3;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // Justification codes
  localparam logic JUSTIFY_LEFT = 1'b0;
  localparam logic JUSTIFY_RIGHT = 1'b1;

  // Positive reference codes
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_RESERVED = 2'h1;
  localparam logic [1:0] REF_EXT_PIN = 2'h2;
  localparam logic [1:0] REF_FIXED = 2'h3;

  // Conversion clock select codes
  localparam logic [2:0] CLK_DIV2 = 3'h0;
  localparam logic [2:0] CLK_DIV8 = 3'h1;
  localparam logic [2:0] CLK_DIV32 = 3'h2;
  localparam logic [2:0] CLK_RC_A = 3'h3;
  localparam logic [2:0] CLK_DIV4 = 3'h4;
  localparam logic [2:0] CLK_DIV16 = 3'h5;
  localparam logic [2:0] CLK_DIV64 = 3'h6;
  localparam logic [2:0] CLK_RC_B = 3'h7;

  // Divider terminal counts (divisor minus one)
  localparam logic [5:0] TC_DIV2 = 6'h01;
  localparam logic [5:0] TC_DIV4 = 6'h03;
  localparam logic [5:0] TC_DIV8 = 6'h07;
  localparam logic [5:0] TC_DIV16 = 6'h0F;
  localparam logic [5:0] TC_DIV32 = 6'h1F;
  localparam logic [5:0] TC_DIV64 = 6'h3F;
  localparam logic [5:0] CNT_ZERO = 6'h00;

  // Result field positions
  localparam int RES_W = 10;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [5:0] PAD6 = 6'h00;
  localparam int RES_MSB = 9;
  localparam int RES_LSB = 0;
  localparam int LEFT_HIGH_LSB = 2;
  localparam int LEFT_LOW_MSB = 1;
  localparam int RIGHT_HIGH_LSB = 8;
  localparam int RIGHT_LOW_MSB = 7;

  // Divider counter step
  localparam logic [5:0] CNT_STEP = 6'h01;

endpackage

// ===== rtl/adc_result_store.sv
`timescale 1ns/1ps
// Two result bytes; no reset so contents survive warm resets
module adc_result_store (
  input wire logic clk_in,
  input wire logic high_we_in,
  input wire logic [7:0] high_wd_in,
  input wire logic low_we_in,
  input wire logic [7:0] low_wd_in,
  output logic [7:0] high_q_out,
  output logic [7:0] low_q_out
);

  logic [7:0] high_r;
  logic [7:0] high_nxt;
  logic [7:0] low_r;
  logic [7:0] low_nxt;

  // Next values: a write replaces the whole byte
  always_comb
  begin
    high_nxt = high_we_in ? high_wd_in : high_r;
    low_nxt = low_we_in ? low_wd_in : low_r;
  end

  // Deliberately unreset: power-up value is unknown, warm reset keeps it
  always_ff @(posedge clk_in)
  begin
    high_r <= high_nxt;
    low_r <= low_nxt;
  end

  assign high_q_out = high_r;
  assign low_q_out = low_r;

endmodule

// ===== tb/adc_result_format_config_checker.sv
`timescale 1ns/1ps
module adc_result_format_config_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [1:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] rd_data_out,
  input wire logic [9:0] conversion_result_in,
  input wire logic result_load_in,
  input wire logic dedicated_rc_clock_in,
  input wire logic [1:0] pos_ref_select_out,
  input wire logic result_justify_select_out,
  input wire logic [2:0] conv_clock_select_out,
  input wire logic conv_clock_tick_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Load then read with no software write in between, so the load alone decides
  logic ld_l, ld_r, rd_h, rd_l;
  assign ld_l = result_load_in && !wr_en_in && !result_justify_select_out;
  assign ld_r = result_load_in && !wr_en_in && result_justify_select_out;
  assign rd_h = rd_en_in && addr_in == 2'h1 && !wr_en_in && !result_load_in;
  assign rd_l = rd_en_in && addr_in == 2'h2 && !wr_en_in && !result_load_in;
  ////////////////////////////////////////////////////////////////////////////////
  a_cfg_read_zero: assert property (
    rd_en_in && addr_in == 2'h0 |=> rd_data_out[3:2] == 2'h0) else $error("cfg 3:2 set");
  a_left_high: assert property (
    ld_l ##1 rd_h |=> rd_data_out == $past(conversion_result_in[9:2], 2))
    else $error("left high wrong");
  a_left_low: assert property (
    ld_l ##1 rd_l |=> rd_data_out[7:6] == $past(conversion_result_in[1:0], 2))
    else $error("left low wrong");
  a_right_high: assert property (
    ld_r ##1 rd_h |=> rd_data_out[1:0] == $past(conversion_result_in[9:8], 2))
    else $error("right high wrong");
  a_right_low: assert property (
    ld_r ##1 rd_l |=> rd_data_out == $past(conversion_result_in[7:0], 2))
    else $error("right low wrong");
  a_ref_follow: assert property (
    wr_en_in && addr_in == 2'h0 |=> pos_ref_select_out == $past(wr_data_in[1:0]))
    else $error("ref select wrong");
  a_clksel_follow: assert property (
    wr_en_in && addr_in == 2'h0 |=> conv_clock_select_out == $past(wr_data_in[6:4]))
    else $error("clock select wrong");
  a_wr_readback: assert property (
    wr_en_in && addr_in == 2'h1 && !result_load_in ##1 rd_h
    |=> rd_data_out == $past(wr_data_in, 2)) else $error("result write lost");
endmodule
bind adc_result_format_config adc_result_format_config_checker chk_i (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .addr_in(addr_in),
  .wr_data_in(wr_data_in),
  .wr_en_in(wr_en_in),
  .rd_en_in(rd_en_in),
  .rd_data_out(rd_data_out),
  .conversion_result_in(conversion_result_in),
  .result_load_in(result_load_in),
  .dedicated_rc_clock_in(dedicated_rc_clock_in),
  .pos_ref_select_out(pos_ref_select_out),
  .result_justify_select_out(result_justify_select_out),
  .conv_clock_select_out(conv_clock_select_out),
  .conv_clock_tick_out(conv_clock_tick_out)
);

// ===== tb/adc_result_format_config_tb.sv
`timescale 1ns/1ps
module adc_result_format_config_tb;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [1:0] addr_in = 2'h0;
  logic [7:0] wr_data_in = 8'h00;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [7:0] rd_data_out;
  logic [9:0] conversion_result_in = 10'h000;
  logic result_load_in = 1'b0;
  logic dedicated_rc_clock_in = 1'b0;
  logic [1:0] pos_ref_select_out;
  logic result_justify_select_out;
  logic [2:0] conv_clock_select_out;
  logic conv_clock_tick_out;
  int failures = 0;
  int n_compared = 0;
  logic [9:0] r;
  logic [7:0] d, n;
  adc_result_format_config uut (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .addr_in(addr_in),
    .wr_data_in(wr_data_in),
    .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out),
    .conversion_result_in(conversion_result_in),
    .result_load_in(result_load_in),
    .dedicated_rc_clock_in(dedicated_rc_clock_in),
    .pos_ref_select_out(pos_ref_select_out),
    .result_justify_select_out(result_justify_select_out),
    .conv_clock_select_out(conv_clock_select_out),
    .conv_clock_tick_out(conv_clock_tick_out)
  );
  always #10 clk_in = ~clk_in;
  // RC pin free-runs out of phase with the system clock
  always #37 dedicated_rc_clock_in = ~dedicated_rc_clock_in;
  ////////////////////////////////////////////////////////////////////////////////
  // Expected byte images of a loaded result
  function automatic logic [7:0] ehi(logic [9:0] v, logic j);
    return j ? {6'h00, v[9:8]} : v[9:2];
  endfunction
  function automatic logic [7:0] elo(logic [9:0] v, logic j);
    return j ? v[7:0] : {v[1:0], 6'h00};
  endfunction
  // Ticks expected in 64 cycles from the divisor of each system clock code
  function automatic logic [7:0] eticks(logic [2:0] c);
    case (c)
      3'h0: return 8'h20;
      3'h4: return 8'h10;
      3'h1: return 8'h08;
      3'h5: return 8'h04;
      3'h2: return 8'h02;
      3'h6: return 8'h01;
      default: return 8'h00;
    endcase
  endfunction
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bus tasks start just after a rising edge; reads check the one-cycle answer
  task wr(input logic [1:0] a, input logic [7:0] v);
    addr_in <= a;
    wr_data_in <= v;
    wr_en_in <= 1'b1;
    @(posedge clk_in);
    wr_en_in <= 1'b0;
  endtask
  task rd(input logic [1:0] a, input logic [7:0] e);
    addr_in <= a;
    rd_en_in <= 1'b1;
    @(posedge clk_in);
    rd_en_in <= 1'b0;
    #1 chk(rd_data_out, e);
  endtask
  task load(input logic [9:0] v);
    conversion_result_in <= v;
    result_load_in <= 1'b1;
    @(posedge clk_in);
    result_load_in <= 1'b0;
  endtask
  task tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial
  begin
    #2000000;
    failures++;
    tally_and_finish;
  end
  initial
  begin
    void'($urandom(32'h81ABBDE9));
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(2'h0, 8'h00);
    // Every clock and reference code, unimplemented bits forced high
    for (int k = 0; k < 8; k++)
    begin
      d = {k[0], k[2:0], 2'h3, k[1:0]};
      wr(2'h0, d);
      rd(2'h0, d & 8'hF3);
      chk({6'h00, pos_ref_select_out}, {6'h00, d[1:0]});
      chk({5'h00, conv_clock_select_out}, {5'h00, d[6:4]});
      chk({7'h00, result_justify_select_out}, {7'h00, d[7]});
    end
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    // Both justifications, all-zero and all-one results first
    for (int i = 0; i < 24; i++)
    begin
      r = (i < 4) ? {10{i[1]}} : 10'($urandom);
      wr(2'h0, {i[0], 7'h00});
      load(r);
      rd(2'h1, ehi(r, i[0]));
      rd(2'h2, elo(r, i[0]));
    end
    // Software writes replace the load and survive a warm reset
    d = 8'($urandom);
    n = 8'($urandom);
    wr(2'h1, d);
    rd(2'h1, d);
    wr(2'h2, n);
    rd(2'h2, n);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    rd(2'h1, d);
    rd(2'h2, n);
    rd(2'h0, 8'h00);
    // Ticks in 64 cycles for every clock code; the 74 ns RC pin gives 17 or 18
    for (int k = 0; k < 8; k++)
    begin
      wr(2'h0, {1'b0, k[2:0], 4'h0});
      repeat (8) @(posedge clk_in);
      n = 8'h00;
      repeat (64)
      begin
        @(posedge clk_in);
        #1 n = n + {7'h00, conv_clock_tick_out};
      end
      if (k[1:0] == 2'h3)
        chk({7'h00, (n >= 8'h11) && (n <= 8'h12)}, 8'h01);
      else
        chk(n, eticks(k[2:0]));
    end
    tally_and_finish;
  end
endmodule
